// ---- verilog/serdes_chan_pkg.sv ----
// Constants, register layout and carrier types for one serial transceiver channel.
// Assumes the core clock is the serial bit clock at 50 MHz and APB with 32-bit data.
//
// Overview of operation
// - Self-test latch turns register into character LFSR.
// - Reset clears the self-test enable latch.
// - Self-test ignores character bits and control bits.
// - Reference-clock receive mode prefixes sixteen sync characters.
// - Reference clock times ten or twenty gives bits.
// - Character clock paces transmit path and goes out.
// - Loopback forces enabled drivers to constant one.
// - Loopback routes transmit stream into recovery input.
// - Disabled drivers power down; both off idles transmitter.
// - Reset disables every serial output driver.
// - Line input select picks one serial input.
// - Link valid needs all seven conditions true.
// - Link fault output changes only on character clock.
// - Amplitude threshold code zero disables, else trips.
// - Loopback ignores amplitude; the other six conditions still apply.
// - More than sixty bits without change faults.
// - Forced oscillator tracking drives fault indicator low.
// - Disabled receive channel holds fault continuously.
`default_nettype none
package serdes_chan_pkg;
   // Register byte offsets.
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   // Control register field positions.
   localparam int SELFTEST_BIT = 0;
   localparam int LOOPBACK_BIT = 1;
   localparam int DRV_A_BIT = 2;
   localparam int DRV_B_BIT = 3;
   localparam int LINE_SEL_BIT = 4;
   localparam int RATE_SEL_BIT = 5;
   localparam int RX_EN_BIT = 6;
   localparam int REF_MODE_BIT = 7;
   localparam int AMP_SEL_LSB = 8;
   localparam int SPEED_LSB = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Timing and pattern counts, in bit clocks or characters.
   localparam int BITS_PER_CHAR = 10;
   localparam int REF_MULT_LOW = 10;
   localparam int REF_MULT_HIGH = 20;
   localparam int TRANSITION_LIMIT_BITS = 60;
   localparam int SYNC_CHARS = 16;
   localparam logic [8:0] LFSR_SEED = 9'h1ff;
   localparam logic [9:0] SYNC_CHAR = 10'h0fa;
   // Speed range codes chosen by the controller.
   typedef enum logic [1:0] {speed_low, speed_mid, speed_high, speed_rsvd} speed_range_t;
   // Control register contents.
   typedef struct packed {
      speed_range_t speed_range_sel;
      logic [1:0] amp_threshold_sel;
      logic rx_ref_mode;
      logic rx_channel_enable_latch;
      logic ref_rate_sel;
      logic line_input_sel;
      logic drv_b_en;
      logic drv_a_en;
      logic local_loopback_en;
      logic tx_selftest_latch;
   } ctrl_t;
   // Status register contents.
   typedef struct packed {
      logic tx_powered;
      logic sync_active;
      logic transition_fault;
      logic ref_present;
      logic link_valid;
   } status_t;
endpackage : serdes_chan_pkg
`default_nettype wire

// ---- verilog/serdes_chan.sv ----
// One transceiver channel: self-test generator, transmit shifter, drivers, input select and link monitor.
// Assumes clk is the bit clock, pins arrive asynchronously and software uses APB.
`default_nettype none
module serdes_chan #(
   parameter int LIMIT_BITS = serdes_chan_pkg::TRANSITION_LIMIT_BITS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] tx_char_bits,
   input wire logic [1:0] tx_char_ctrl,
   input wire logic channel_ref_clock,
   input wire logic serial_in_primary,
   input wire logic serial_in_secondary,
   input wire logic [1:0] amp_level_primary,
   input wire logic [1:0] amp_level_secondary,
   input wire logic vco_in_range,
   input wire logic range_force,
   input wire logic link_fault_override,
   output logic serial_out_a,
   output logic serial_out_a_oe,
   output logic serial_out_b,
   output logic serial_out_b_oe,
   output logic tx_char_clock_out,
   output logic [1:0] speed_range_sel,
   output logic link_fault_n
);
   serdes_chan_pkg::ctrl_t ctrl;
   serdes_chan_pkg::status_t status;
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [3:0] amp_s1;
   logic [3:0] amp_s2;
   logic ref_prev;
   logic ref_edge;
   logic [4:0] ref_gap;
   logic ref_present;
   logic [3:0] bit_cnt;
   logic char_tick;
   logic [9:0] shifter;
   logic [9:0] next_char;
   logic [8:0] lfsr;
   logic [4:0] sync_cnt;
   logic selftest_d;
   logic tx_powered;
   logic tx_bit;
   logic rx_bit;
   logic rx_prev;
   logic [6:0] quiet_cnt;
   logic transition_fault;
   logic amp_ok;
   logic link_valid;

   // Minimum amplitude level that the selected threshold code demands.
   function automatic logic amp_passes(input logic [1:0] sel, input logic [1:0] level);
      amp_passes = (sel == 2'h0) || (level >= sel);
   endfunction : amp_passes

   // Reference, line, amplitude and monitor pins pass two flip-flops before any logic reads them; APB and character inputs do not.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
         amp_s1 <= 4'h0;
         amp_s2 <= 4'h0;
      end else begin
         pin_s1 <= {channel_ref_clock, serial_in_primary, serial_in_secondary,
                    vco_in_range, range_force, link_fault_override};
         pin_s2 <= pin_s1;
         amp_s1 <= {amp_level_primary, amp_level_secondary};
         amp_s2 <= amp_s1;
      end
   end

   // APB slave with no wait states; writes and reads complete in the access phase.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl <= serdes_chan_pkg::ctrl_t'(serdes_chan_pkg::CTRL_RESET[11:0]);
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= 1'b0;
         if (psel && !penable && !pready) begin
            prdata <= 32'h0000_0000;
            if (paddr == serdes_chan_pkg::CTRL_OFFSET) begin
               prdata <= {20'h00000, ctrl};
            end else if (paddr == serdes_chan_pkg::STATUS_OFFSET) begin
               prdata <= {27'h0000000, status};
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (psel && penable && pready && pwrite && paddr == serdes_chan_pkg::CTRL_OFFSET) begin
            ctrl <= serdes_chan_pkg::ctrl_t'(pwdata[11:0]);
         end
      end
   end

   assign status = '{tx_powered: tx_powered, sync_active: (sync_cnt != 5'h00),
                     transition_fault: transition_fault, ref_present: ref_present, link_valid: link_valid};

   // Speed range is a plain level handed to the analog section.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         speed_range_sel <= 2'h0;
      end else begin
         speed_range_sel <= ctrl.speed_range_sel;
      end
   end

   // Reference clock presence: an edge must come within one and a half reference periods of bits.
   assign ref_edge = pin_s2[5] && !ref_prev;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ref_prev <= 1'b0;
         ref_gap <= 5'h00;
         ref_present <= 1'b0;
      end else begin
         ref_prev <= pin_s2[5];
         if (ref_edge) begin
            ref_gap <= 5'h00;
            ref_present <= 1'b1;
         end else if (ref_gap == 5'((ctrl.ref_rate_sel ? serdes_chan_pkg::REF_MULT_HIGH
                                                         : serdes_chan_pkg::REF_MULT_LOW) * 3 / 2)) begin
            ref_present <= 1'b0;
         end else begin
            ref_gap <= ref_gap + 5'h01;
         end
      end
   end

   // Character divider: ten bits per character, held at zero one extra bit when a present reference edge lands on count zero.
   assign char_tick = (bit_cnt == 4'(serdes_chan_pkg::BITS_PER_CHAR - 1));
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bit_cnt <= 4'h0;
         tx_char_clock_out <= 1'b0;
      end else begin
         if (char_tick || (ref_edge && ref_present && bit_cnt == 4'h0)) begin
            bit_cnt <= 4'h0;
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
         end
         tx_char_clock_out <= (bit_cnt < 4'(serdes_chan_pkg::BITS_PER_CHAR / 2));
      end
   end

   // Next character: self-test pattern or sync prefix, else the user's character.
   always_comb begin
      if (ctrl.tx_selftest_latch) begin
         if (sync_cnt != 5'h00) begin
            next_char = serdes_chan_pkg::SYNC_CHAR;
         end else begin
            next_char = {lfsr[0], lfsr};
         end
      end else begin
         next_char = {tx_char_ctrl, tx_char_bits};
      end
   end

   // Self-test LFSR steps once a character and restarts on a rising enable.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         lfsr <= serdes_chan_pkg::LFSR_SEED;
         sync_cnt <= 5'h00;
         selftest_d <= 1'b0;
      end else begin
         selftest_d <= ctrl.tx_selftest_latch;
         if (ctrl.tx_selftest_latch && !selftest_d) begin
            lfsr <= serdes_chan_pkg::LFSR_SEED;
            sync_cnt <= ctrl.rx_ref_mode ? 5'(serdes_chan_pkg::SYNC_CHARS) : 5'h00;
         end else if (char_tick && ctrl.tx_selftest_latch && tx_powered) begin
            if (sync_cnt != 5'h00) begin
               sync_cnt <= sync_cnt - 5'h01;
            end else begin
               lfsr <= {lfsr[0] ^ lfsr[4], lfsr[8:1]};
               if ({lfsr[0] ^ lfsr[4], lfsr[8:1]} == serdes_chan_pkg::LFSR_SEED && ctrl.rx_ref_mode) begin
                  sync_cnt <= 5'(serdes_chan_pkg::SYNC_CHARS);
               end
            end
         end
      end
   end

   // Transmit shifter sends LSB first; it idles when both drivers are off.
   assign tx_powered = ctrl.drv_a_en || ctrl.drv_b_en;
   assign tx_bit = shifter[0];
   always_ff @(posedge clk) begin
      if (!rstn) begin
         shifter <= 10'h000;
      end else if (tx_powered) begin
         if (char_tick) begin
            shifter <= next_char;
         end else begin
            shifter <= {1'b0, shifter[9:1]};
         end
      end
   end

   // Drivers: disabled ones are off and low, loopback forces a steady one.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         serial_out_a <= 1'b0;
         serial_out_b <= 1'b0;
         serial_out_a_oe <= 1'b0;
         serial_out_b_oe <= 1'b0;
      end else begin
         serial_out_a_oe <= ctrl.drv_a_en;
         serial_out_b_oe <= ctrl.drv_b_en;
         serial_out_a <= ctrl.drv_a_en && (ctrl.local_loopback_en || tx_bit);
         serial_out_b <= ctrl.drv_b_en && (ctrl.local_loopback_en || tx_bit);
      end
   end

   // Recovery input: looped transmit stream or exactly one of the two lines.
   always_comb begin
      if (ctrl.local_loopback_en) begin
         rx_bit = tx_bit;
      end else if (ctrl.line_input_sel) begin
         rx_bit = pin_s2[3];
      end else begin
         rx_bit = pin_s2[4];
      end
   end

   // Transition checker counts quiet bit times and faults past the limit.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_prev <= 1'b0;
         quiet_cnt <= 7'h00;
         transition_fault <= 1'b1;
      end else begin
         rx_prev <= rx_bit;
         if (rx_bit != rx_prev) begin
            quiet_cnt <= 7'h00;
            transition_fault <= 1'b0;
         end else if (quiet_cnt >= 7'(LIMIT_BITS)) begin
            transition_fault <= 1'b1;
         end else begin
            quiet_cnt <= quiet_cnt + 7'h01;
         end
      end
   end

   // Amplitude from the selected receiver; not consulted in loopback.
   assign amp_ok = ctrl.local_loopback_en
                   || amp_passes(ctrl.amp_threshold_sel, ctrl.line_input_sel ? amp_s2[1:0] : amp_s2[3:2]);
   assign link_valid = amp_ok && !transition_fault && pin_s2[2] && !pin_s2[1]
                       && ctrl.rx_channel_enable_latch && ref_present && !pin_s2[0];

   // Fault indicator changes only on the character clock; low means fault.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         link_fault_n <= 1'b0;
      end else if (char_tick) begin
         link_fault_n <= link_valid;
      end
   end

   // Assertion helpers: cycles that the receive enable has stayed off and forced tracking has stayed on.
   logic [3:0] rx_off_cycles;
   logic [3:0] force_cycles;
   always_ff @(posedge clk) begin
      if (!rstn || ctrl.rx_channel_enable_latch) begin
         rx_off_cycles <= 4'h0;
      end else if (rx_off_cycles != 4'hf) begin
         rx_off_cycles <= rx_off_cycles + 4'h1;
      end
   end
   // The counts saturate, so a long hold never wraps back into the grace period.
   always_ff @(posedge clk) begin
      if (!rstn || !pin_s2[1]) begin
         force_cycles <= 4'h0;
      end else if (force_cycles != 4'hf) begin
         force_cycles <= force_cycles + 4'h1;
      end
   end

   chk_reset_clears_selftest: assert property (@(posedge clk) !rstn |=> !ctrl.tx_selftest_latch)
      else $error("self-test latch survived reset");
   chk_reset_drivers_off: assert property (@(posedge clk) !rstn ##1 !rstn |=> !serial_out_a_oe && !serial_out_b_oe)
      else $error("driver enabled after reset");
   chk_loopback_ones: assert property (@(posedge clk) disable iff (!rstn)
      $past(ctrl.local_loopback_en && ctrl.drv_a_en) |-> serial_out_a)
      else $error("driver not steady one in loopback");
   chk_fault_only_tick: assert property (@(posedge clk) disable iff (!rstn)
      !$past(char_tick) |-> $stable(link_fault_n))
      else $error("fault indicator moved off character clock");
   chk_disabled_rx_fault: assert property (@(posedge clk) disable iff (!rstn)
      rx_off_cycles >= 4'hb |-> !link_fault_n)
      else $error("disabled channel reports no fault");
   chk_quiet_line_fault: assert property (@(posedge clk) disable iff (!rstn)
      quiet_cnt >= 7'(LIMIT_BITS) && rx_bit == rx_prev |=> transition_fault)
      else $error("quiet line not flagged");
   chk_change_clears_count: assert property (@(posedge clk) disable iff (!rstn)
      rx_bit != rx_prev |=> quiet_cnt == 7'h00)
      else $error("transition did not clear quiet count");
   chk_restart_seed: assert property (@(posedge clk) disable iff (!rstn)
      $rose(ctrl.tx_selftest_latch) |=> lfsr == serdes_chan_pkg::LFSR_SEED)
      else $error("pattern did not restart");
   chk_selftest_ignores_input: assert property (@(posedge clk) disable iff (!rstn)
      ctrl.tx_selftest_latch && sync_cnt == 5'h00 |-> next_char == {lfsr[0], lfsr})
      else $error("user bits leak into self-test");
   chk_sync_prefix: assert property (@(posedge clk) disable iff (!rstn)
      $rose(ctrl.tx_selftest_latch) && ctrl.rx_ref_mode |=> sync_cnt == 5'(serdes_chan_pkg::SYNC_CHARS))
      else $error("sync prefix missing");
   chk_char_divider: assert property (@(posedge clk) disable iff (!rstn)
      char_tick |=> bit_cnt == 4'h0 ##9 char_tick)
      else $error("character divider off");
   chk_power_down: assert property (@(posedge clk) disable iff (!rstn)
      !tx_powered |=> $stable(shifter))
      else $error("shifter runs with both drivers off");
   chk_range_force_fault: assert property (@(posedge clk) disable iff (!rstn)
      force_cycles >= 4'hb |-> !link_fault_n)
      else $error("forced tracking not flagged");
   cov_link_up: cover property (@(posedge clk) disable iff (!rstn) $rose(link_fault_n));
   cov_selftest_pass: cover property (@(posedge clk) disable iff (!rstn)
      ctrl.tx_selftest_latch && char_tick && lfsr == serdes_chan_pkg::LFSR_SEED && $past(lfsr) != lfsr);
   cov_loopback_link: cover property (@(posedge clk) disable iff (!rstn) ctrl.local_loopback_en && link_fault_n);
endmodule : serdes_chan
`default_nettype wire

// ---- verif/serdes_link_partner.sv ----
// Remote link partner: drives both serial line inputs and the amplitude each line shows.
// Assumes it shares the bench clock; a line that is not running stays flat, as a silent cable would.
`default_nettype none
module serdes_link_partner (
   input wire logic clk,
   input wire logic run_primary,
   input wire logic run_secondary,
   input wire logic [1:0] amp,
   output logic line_primary,
   output logic line_secondary,
   output logic [1:0] amp_primary,
   output logic [1:0] amp_secondary
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase;
   // Lines start flat before any traffic.
   initial begin
      phase = 2'h0;
      line_primary = 1'b0;
      line_secondary = 1'b0;
   end
   // A running line sends 0011 over and over, so it changes every two bits.
   always @(posedge clk) begin
      phase <= phase + 2'h1;
      if (run_primary) line_primary <= phase[1];
      if (run_secondary) line_secondary <= ~phase[1];
   end
   // A silent line has no swing, so it reports no amplitude at all.
   assign amp_primary = run_primary ? amp : 2'h0;
   assign amp_secondary = run_secondary ? amp : 2'h0;
endmodule : serdes_link_partner
`default_nettype wire

// ---- verif/serdes_chan_tb_top.sv ----
// Self-checking bench for one transceiver channel: APB set-up, drivers, self-test and link monitor.
// Assumes the channel package and the link partner are compiled first.
`default_nettype none
module serdes_chan_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0] tx_char_bits = 8'h00;
   logic [1:0] tx_char_ctrl = 2'h0;
   logic ref_clk = 1'b0;
   logic [3:0] ref_cnt = 4'h0;
   logic run_p = 1'b0;
   logic run_s = 1'b0;
   logic [1:0] amp = 2'h0;
   logic vco_ok = 1'b0;
   logic force_ref = 1'b0;
   logic ovr = 1'b0;
   wire logic in_p, in_s, out_a, oe_a, out_b, oe_b, char_clk, lfn, pready, pslverr;
   wire logic [1:0] amp_p, amp_s, speed;
   wire logic [31:0] prdata;
   logic [31:0] rd;
   logic err;
   int err_count = 0;
   int tests_run = 0;

   // Bench clock at 50 MHz.
   always #10 clk = ~clk;
   // Reference clock at a tenth of the bit rate, as rate select 0 needs.
   always @(posedge clk) begin
      ref_cnt <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
      ref_clk <= (ref_cnt < 4'h5);
   end

   serdes_chan #(.LIMIT_BITS(8)) dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_char_bits(tx_char_bits), .tx_char_ctrl(tx_char_ctrl), .channel_ref_clock(ref_clk),
      .serial_in_primary(in_p), .serial_in_secondary(in_s), .amp_level_primary(amp_p),
      .amp_level_secondary(amp_s), .vco_in_range(vco_ok), .range_force(force_ref),
      .link_fault_override(ovr), .serial_out_a(out_a), .serial_out_a_oe(oe_a), .serial_out_b(out_b),
      .serial_out_b_oe(oe_b), .tx_char_clock_out(char_clk), .speed_range_sel(speed), .link_fault_n(lfn));

   serdes_link_partner partner_u (.clk(clk), .run_primary(run_p), .run_secondary(run_s), .amp(amp),
      .line_primary(in_p), .line_secondary(in_s), .amp_primary(amp_p), .amp_secondary(amp_s));

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // Compares one value and counts the result.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk

   // One APB transfer; the answer is taken at the edge where pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1'b1, pready);
      if (pready !== 1'b1) end_sim();
   endtask : apb

   // Waits a bounded time for the fault indicator to reach a level.
   task automatic wait_lfn(input logic v, input string what);
      for (int n = 0; n < 300 && lfn !== v; n++) @(posedge clk);
      chk(what, v, lfn);
      if (lfn !== v) end_sim();
   endtask : wait_lfn

   // Reset state and an unmapped address.
   task automatic t_reset();
      chk("oe after reset", 2'h0, {oe_a, oe_b});
      chk("fault after reset", 1'b0, lfn);
      apb(1'b0, serdes_chan_pkg::CTRL_OFFSET, 32'h0);
      chk("ctrl reset", serdes_chan_pkg::CTRL_RESET, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped error", 1'b1, err);
      $display("test reset done");
   endtask : t_reset

   // Driver enables, self-test and loopback on the serial outputs.
   task automatic t_drivers();
      logic seen;
      apb(1'b1, 12'h000, 32'h0000_0004);
      repeat (12) @(posedge clk);
      chk("oe pair", 2'h2, {oe_a, oe_b});
      chk("zero char", 1'b0, out_a);
      apb(1'b1, 12'h000, 32'h0000_0005);
      seen = 1'b0;
      repeat (40) begin
         @(posedge clk);
         seen = seen | (out_a === 1'b1);
      end
      chk("self-test pattern", 1'b1, seen);
      apb(1'b1, 12'h000, 32'h0000_000e);
      repeat (3) @(posedge clk);
      repeat (30) begin
         @(posedge clk);
         chk("loopback level", 2'h3, {out_a, out_b});
      end
      // Self-test in reference-clock receive mode starts with the sync prefix, which then runs out.
      apb(1'b1, 12'h000, 32'h0000_0085);
      apb(1'b0, serdes_chan_pkg::STATUS_OFFSET, 32'h0);
      chk("sync prefix active", 2'h3, rd[4:3]);
      repeat (170) @(posedge clk);
      apb(1'b0, serdes_chan_pkg::STATUS_OFFSET, 32'h0);
      chk("sync prefix over", 1'b0, rd[3]);
      $display("test drivers done");
   endtask : t_drivers

   // Character clock duty and speed range output.
   task automatic t_clock();
      int highs;
      highs = 0;
      repeat (100) begin
         @(posedge clk);
         highs += (char_clk === 1'b1);
      end
      chk("char clock highs", 32'd50, highs);
      apb(1'b1, 12'h000, 32'h0000_0800);
      repeat (2) @(posedge clk);
      chk("speed range", 2'h2, speed);
      $display("test clock done");
   endtask : t_clock

   // Override, range force, amplitude, transitions and receive enable in turn, with both line inputs.
   task automatic t_link();
      vco_ok <= 1'b1;
      amp <= 2'h2;
      run_p <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_0240);
      wait_lfn(1'b1, "link valid");
      ovr <= 1'b1;
      wait_lfn(1'b0, "override");
      ovr <= 1'b0;
      wait_lfn(1'b1, "override released");
      force_ref <= 1'b1;
      wait_lfn(1'b0, "range force");
      force_ref <= 1'b0;
      wait_lfn(1'b1, "range force released");
      amp <= 2'h1;
      wait_lfn(1'b0, "low amplitude");
      amp <= 2'h2;
      wait_lfn(1'b1, "amplitude back");
      // Threshold code zero, so only the missing transitions can fault the quiet line.
      apb(1'b1, 12'h000, 32'h0000_0040);
      run_p <= 1'b0;
      wait_lfn(1'b0, "no transitions");
      run_s <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_0250);
      wait_lfn(1'b1, "secondary line");
      apb(1'b1, 12'h000, 32'h0000_0210);
      wait_lfn(1'b0, "rx disabled");
      $display("test link done");
   endtask : t_link

   // Loopback of the self-test pattern with no line amplitude at all.
   task automatic t_loop();
      run_s <= 1'b0;
      amp <= 2'h0;
      apb(1'b1, 12'h000, 32'h0000_034f);
      wait_lfn(1'b1, "loopback link");
      $display("test loopback done");
   endtask : t_loop

   // Main sequence: reset for four cycles, then every test.
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_drivers();
      t_clock();
      t_link();
      t_loop();
      end_sim();
   end

   // Cuts a hang short.
   initial begin
      #1000000;
      err_count++;
      end_sim();
   end
endmodule : serdes_chan_tb_top
`default_nettype wire
